// File: rom_ctl_pkg.sv
// package: register map, reset values and types for the rom controller
`default_nettype none
package rom_ctl_pkg;
    // ************************************************************
    // register byte addresses (all multiples of four except 0x5816)
    // ************************************************************
    localparam logic [15:0] ADDR_WAIT      = 16'h5804;
    localparam logic [15:0] ADDR_UNLOCK    = 16'h5810;
    localparam logic [15:0] ADDR_BASE_LOW  = 16'h5814;
    localparam logic [15:0] ADDR_BASE_HIGH = 16'h5816;

    // ************************************************************
    // rom region, field layout and reset values
    // ************************************************************
    localparam logic [23:0] ROM_FIRST      = 24'h020000;
    localparam logic [23:0] ROM_LAST       = 24'h03FFFF;
    localparam int          WAIT_W         = 3;
    localparam logic [2:0]  WAIT_RST       = 3'h7;
    localparam logic [7:0]  UNLOCK_KEY     = 8'h96;
    localparam logic [7:0]  UNLOCK_RST     = 8'h00;
    localparam logic [7:0]  BASE_MID_RST   = 8'h00;
    localparam logic [7:0]  BASE_HIGH_RST  = 8'h02;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // rom fetch request from the cpu
    typedef struct packed {
        logic        valid;
        logic [23:0] addr;
    } fetch_req_t;

    // rom fetch answer to the cpu
    typedef struct packed {
        logic        ready;
        logic        hit;
        logic [15:0] data;
    } fetch_rsp_t;

    typedef enum logic [1:0] {
        FETCH_IDLE,
        FETCH_WAIT,
        FETCH_DONE
    } fetch_state_t;
endpackage
`default_nettype wire

// File: rom_ctl.sv
// rom controller: wait-state fetch sequencer and vector base registers
`default_nettype none
module rom_ctl #(
    parameter int ROM_WORDS = 65536
) (
    input  wire logic                       CORE_CLK_IN,
    input  wire logic                       NRST_IN,
    // axi4-lite write address
    input  wire logic                       AWVALID_IN,
    output logic                            AWREADY_OUT,
    input  wire logic [15:0]                AWADDR_IN,
    // axi4-lite write data
    input  wire logic                       WVALID_IN,
    output logic                            WREADY_OUT,
    input  wire logic [31:0]                WDATA_IN,
    input  wire logic [3:0]                 WSTRB_IN,
    // axi4-lite write response
    output logic                            BVALID_OUT,
    input  wire logic                       BREADY_IN,
    output logic [1:0]                      BRESP_OUT,
    // axi4-lite read address
    input  wire logic                       ARVALID_IN,
    output logic                            ARREADY_OUT,
    input  wire logic [15:0]                ARADDR_IN,
    // axi4-lite read data
    output logic                            RVALID_OUT,
    input  wire logic                       RREADY_IN,
    output logic [31:0]                     RDATA_OUT,
    output logic [1:0]                      RRESP_OUT,
    // cpu rom fetch port
    input  wire rom_ctl_pkg::fetch_req_t    FETCH_REQ_IN,
    output rom_ctl_pkg::fetch_rsp_t         FETCH_RSP_OUT,
    // rom array load port
    input  wire logic                       LOAD_WE_IN,
    input  wire logic [15:0]                LOAD_ADDR_IN,
    input  wire logic [15:0]                LOAD_DATA_IN,
    // vector table base to the core
    output logic [23:0]                     VECTOR_BASE_OUT
);

    // ************************************************************
    // helper functions
    // ************************************************************

    // true when a byte address lies inside the rom region
    function automatic logic in_rom(input logic [23:0] a);
        in_rom = (a >= rom_ctl_pkg::ROM_FIRST) &&
                 (a <= rom_ctl_pkg::ROM_LAST);
    endfunction

    // merge write data into a 16-bit register under the byte strobes
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ************************************************************
    // registers
    // ************************************************************
    logic [rom_ctl_pkg::WAIT_W-1:0] wait_r;
    logic [7:0]                     unlock_r;
    logic [7:0]                     base_mid_r;
    logic [7:0]                     base_high_r;

    logic                           aw_held_r;
    logic [15:0]                    aw_addr_r;
    logic                           w_held_r;
    logic [31:0]                    w_data_r;
    logic [3:0]                     w_strb_r;
    logic                           wr_go;
    logic                           wr_hit;
    logic [15:0]                    wait_merge;
    logic [15:0]                    unlock_merge;

    logic [15:0]                    rom_mem [ROM_WORDS];

    // ************************************************************
    // axi4-lite write channels
    // ************************************************************

    // address and data latched independently, in either order
    assign wr_go = aw_held_r && w_held_r && !BVALID_OUT;

    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            aw_held_r   <= 1'b0;
            aw_addr_r   <= 16'h0000;
            AWREADY_OUT <= 1'b0;
        end else begin
            AWREADY_OUT <= !aw_held_r && !(AWVALID_IN && AWREADY_OUT);
            if (AWVALID_IN && AWREADY_OUT) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= AWADDR_IN;
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            w_held_r   <= 1'b0;
            w_data_r   <= 32'h0000_0000;
            w_strb_r   <= 4'h0;
            WREADY_OUT <= 1'b0;
        end else begin
            WREADY_OUT <= !w_held_r && !(WVALID_IN && WREADY_OUT);
            if (WVALID_IN && WREADY_OUT) begin
                w_held_r <= 1'b1;
                w_data_r <= WDATA_IN;
                w_strb_r <= WSTRB_IN;
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // unmapped addresses answer slverr, writes there do nothing
    assign wr_hit = (aw_addr_r[15:2] == rom_ctl_pkg::ADDR_WAIT[15:2]) ||
                    (aw_addr_r[15:2] == rom_ctl_pkg::ADDR_UNLOCK[15:2]) ||
                    (aw_addr_r[15:2] == rom_ctl_pkg::ADDR_BASE_LOW[15:2]) ||
                    (aw_addr_r[15:2] == rom_ctl_pkg::ADDR_BASE_HIGH[15:2]);

    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            BVALID_OUT <= 1'b0;
            BRESP_OUT  <= rom_ctl_pkg::RESP_OKAY;
        end else if (wr_go) begin
            BVALID_OUT <= 1'b1;
            BRESP_OUT  <= wr_hit ? rom_ctl_pkg::RESP_OKAY
                                 : rom_ctl_pkg::RESP_SLVERR;
        end else if (BREADY_IN) begin
            BVALID_OUT <= 1'b0;
        end
    end

    // ************************************************************
    // register writes
    // ************************************************************

    // strobe-merged views; a call result cannot be part-selected directly
    assign wait_merge   = merge16({13'h0000, wait_r}, w_data_r, w_strb_r);
    assign unlock_merge = merge16({8'h00, unlock_r}, w_data_r, w_strb_r);

    // wait setting and unlock key are always writable
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            wait_r   <= rom_ctl_pkg::WAIT_RST;
            unlock_r <= rom_ctl_pkg::UNLOCK_RST;
        end else if (wr_go) begin
            if (aw_addr_r == rom_ctl_pkg::ADDR_WAIT) begin
                wait_r <= wait_merge[rom_ctl_pkg::WAIT_W-1:0];
            end else if (aw_addr_r == rom_ctl_pkg::ADDR_UNLOCK) begin
                unlock_r <= unlock_merge[7:0];
            end
        end
    end

    // base halves share one word; 0x5816 is the upper half-word
    // boot at rom
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            base_mid_r  <= rom_ctl_pkg::BASE_MID_RST;
            base_high_r <= rom_ctl_pkg::BASE_HIGH_RST;
        end else if (wr_go && unlock_r == rom_ctl_pkg::UNLOCK_KEY &&
                     aw_addr_r[15:2] == rom_ctl_pkg::ADDR_BASE_LOW[15:2]) begin
            if (w_strb_r[1]) begin
                base_mid_r <= w_data_r[15:8];
            end
            if (w_strb_r[2]) begin
                base_high_r <= w_data_r[23:16];
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            VECTOR_BASE_OUT <= rom_ctl_pkg::ROM_FIRST;
        end else begin
            VECTOR_BASE_OUT <= {base_high_r, base_mid_r, 8'h00};
        end
    end

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************

    // one read at a time; arready drops until the data is taken
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            ARREADY_OUT <= 1'b0;
            RVALID_OUT  <= 1'b0;
            RDATA_OUT   <= 32'h0000_0000;
            RRESP_OUT   <= rom_ctl_pkg::RESP_OKAY;
        end else begin
            ARREADY_OUT <= !RVALID_OUT && !(ARVALID_IN && ARREADY_OUT);
            if (ARVALID_IN && ARREADY_OUT) begin
                RVALID_OUT <= 1'b1;
                RRESP_OUT  <= rom_ctl_pkg::RESP_OKAY;
                if (ARADDR_IN[15:2] == rom_ctl_pkg::ADDR_WAIT[15:2]) begin
                    RDATA_OUT <= {29'h0000_0000, wait_r};
                end else if (ARADDR_IN[15:2] ==
                             rom_ctl_pkg::ADDR_UNLOCK[15:2]) begin
                    RDATA_OUT <= {24'h00_0000, unlock_r};
                end else if (ARADDR_IN[15:2] ==
                             rom_ctl_pkg::ADDR_BASE_LOW[15:2]) begin
                    RDATA_OUT <= {8'h00, base_high_r, base_mid_r, 8'h00};
                end else begin
                    RDATA_OUT <= 32'h0000_0000;
                    RRESP_OUT <= rom_ctl_pkg::RESP_SLVERR;
                end
            end else if (RREADY_IN) begin
                RVALID_OUT <= 1'b0;
            end
        end
    end

    // ************************************************************
    // rom fetch sequencer
    // ************************************************************
    rom_ctl_pkg::fetch_state_t state_r;
    logic [rom_ctl_pkg::WAIT_W-1:0] wcnt_r;
    logic [23:0]                    faddr_r;

    // rom array; contents come from the load port
    always_ff @(posedge CORE_CLK_IN) begin
        if (LOAD_WE_IN) begin
            rom_mem[LOAD_ADDR_IN] <= LOAD_DATA_IN;
        end
    end

    // response registered: ready rises n+1 cycles after the request edge,
    // so zero wait still costs one registered cycle per fetch
    // rom window
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            state_r       <= rom_ctl_pkg::FETCH_IDLE;
            wcnt_r        <= '0;
            faddr_r       <= 24'h000000;
            FETCH_RSP_OUT <= '0;
        end else begin
            case (state_r)
                rom_ctl_pkg::FETCH_IDLE: begin
                    FETCH_RSP_OUT <= '0;
                    if (FETCH_REQ_IN.valid) begin
                        faddr_r <= FETCH_REQ_IN.addr;
                        if (wait_r == '0) begin
                            FETCH_RSP_OUT.ready <= 1'b1;
                            FETCH_RSP_OUT.hit   <= in_rom(FETCH_REQ_IN.addr);
                            FETCH_RSP_OUT.data  <=
                                in_rom(FETCH_REQ_IN.addr)
                                ? rom_mem[FETCH_REQ_IN.addr[16:1]] : 16'h0000;
                            state_r <= rom_ctl_pkg::FETCH_DONE;
                        end else begin
                            wcnt_r  <= wait_r;
                            state_r <= rom_ctl_pkg::FETCH_WAIT;
                        end
                    end
                end
                rom_ctl_pkg::FETCH_WAIT: begin
                    if (wcnt_r == 3'h1) begin
                        FETCH_RSP_OUT.ready <= 1'b1;
                        FETCH_RSP_OUT.hit   <= in_rom(faddr_r);
                        FETCH_RSP_OUT.data  <= in_rom(faddr_r)
                                               ? rom_mem[faddr_r[16:1]]
                                               : 16'h0000;
                        state_r <= rom_ctl_pkg::FETCH_DONE;
                    end
                    wcnt_r <= wcnt_r - 3'h1;
                end
                default: begin
                    // one-cycle answer, back to idle
                    FETCH_RSP_OUT <= '0;
                    state_r       <= rom_ctl_pkg::FETCH_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// File: rom_ctl_asserts.sv
// checker: fetch timing, vector base and bus rules of rom_ctl
`default_nettype none
module rom_ctl_asserts (
    input wire logic                    CORE_CLK_IN,
    input wire logic                    NRST_IN,
    input wire logic                    BVALID_OUT,
    input wire logic                    ARREADY_OUT,
    input wire logic                    RVALID_OUT,
    input wire rom_ctl_pkg::fetch_req_t FETCH_REQ_IN,
    input wire rom_ctl_pkg::fetch_rsp_t FETCH_RSP_OUT,
    input wire logic [23:0]             VECTOR_BASE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    // *******************
    // fetch sequencing
    // *******************
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!NRST_IN);
    // a new request, seen on the edge that takes it
    sequence s_take;
        $rose(FETCH_REQ_IN.valid);
    endsequence
    // answer after at most seven waits, one cycle wide
    sequence s_answer;
        ##[1:8] FETCH_RSP_OUT.ready ##1 !FETCH_RSP_OUT.ready;
    endsequence
    a_fetch_answer: assert property (s_take |-> s_answer)
        else $error("fetch answer missing or late");
    a_wait_stall: assert property (s_take |-> !FETCH_RSP_OUT.ready)
        else $error("fetch answered during wait");
    a_answer_req: assert property (FETCH_RSP_OUT.ready |-> FETCH_REQ_IN.valid)
        else $error("fetch answer without request");
    a_hit_range: assert property (FETCH_RSP_OUT.ready |-> FETCH_RSP_OUT.hit
        == (FETCH_REQ_IN.addr inside {[24'h020000:24'h03FFFF]}))
        else $error("rom hit flag wrong for address");
    a_miss_zero: assert property (FETCH_RSP_OUT.ready && !FETCH_RSP_OUT.hit
        |-> FETCH_RSP_OUT.data == 16'h0000) else $error("miss data not zero");
    // *******************
    // vector base and bus
    // *******************
    a_base_align: assert property (VECTOR_BASE_OUT[7:0] == 8'h00)
        else $error("vector base not 256 aligned");
    a_base_boot: assert property ($rose(NRST_IN) |-> VECTOR_BASE_OUT == 24'h020000)
        else $error("vector base not at rom start");
    // base may move only right around a write response
    a_base_by_bus: assert property ($changed(VECTOR_BASE_OUT) |-> BVALID_OUT
        || $past(BVALID_OUT) || $past(BVALID_OUT, 2)) else $error("base moved");
    a_ar_blocked: assert property (RVALID_OUT |-> !ARREADY_OUT)
        else $error("read address taken while data pending");
endmodule
bind rom_ctl rom_ctl_asserts u_asserts (
    .CORE_CLK_IN(CORE_CLK_IN), .NRST_IN(NRST_IN), .BVALID_OUT(BVALID_OUT),
    .ARREADY_OUT(ARREADY_OUT), .RVALID_OUT(RVALID_OUT),
    .FETCH_REQ_IN(FETCH_REQ_IN), .FETCH_RSP_OUT(FETCH_RSP_OUT),
    .VECTOR_BASE_OUT(VECTOR_BASE_OUT)
);
`default_nettype wire

// File: cpu_fetch_model.sv
// cpu side model: issues rom fetches and holds them until answered
`default_nettype none
module cpu_fetch_model (
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    input  wire logic                    go_in,
    input  wire logic [23:0]             addr_in,
    input  wire rom_ctl_pkg::fetch_rsp_t rsp_in,
    output rom_ctl_pkg::fetch_req_t      req_out,
    output logic                         done_out,
    output logic [15:0]                  data_out,
    output logic                         hit_out,
    output logic [4:0]                   lat_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_out = '0;
    // hold until served; lat counts edges with valid up
    always @(posedge clk_in) begin
        done_out <= 1'b0;
        if (!rst_n_in) begin
            req_out <= '0;
        end else if (go_in) begin
            req_out <= {1'b1, addr_in};
            lat_out <= 5'h00;
        end else if (req_out.valid) begin
            lat_out <= lat_out + 5'h01;
            if (rsp_in.ready) begin
                // released address flips so a stale value never matches
                req_out  <= {1'b0, ~req_out.addr};
                done_out <= 1'b1;
                data_out <= rsp_in.data;
                hit_out  <= rsp_in.hit;
            end
        end
    end
endmodule
`default_nettype wire

// File: test_rom_ctl.sv
// testbench for rom_ctl: register bus, vector base and fetch timing
`default_nettype none
module test_rom_ctl;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, nrst, aw_v, w_v, b_r, ar_v, r_r, ld_we, go, f_hit, done;
    logic [15:0] aw_a, ar_a, ld_a, ld_d, f_data, ix;
    logic [31:0] w_d, seed, d, v;
    logic [3:0]  w_s;
    logic [1:0]  r;
    logic [4:0]  f_lat;
    logic [23:0] f_addr, eb, base;
    rom_ctl_pkg::fetch_req_t req;
    rom_ctl_pkg::fetch_rsp_t rsp;
    int          n_fail, samples_checked;
    logic        bv, awr, wr, arr, rv;
    logic [1:0]  br, rr;
    logic [31:0] rd;
    rom_ctl dut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .AWVALID_IN(aw_v),
        .AWREADY_OUT(awr), .AWADDR_IN(aw_a), .WVALID_IN(w_v), .WREADY_OUT(wr),
        .WDATA_IN(w_d), .WSTRB_IN(w_s), .BVALID_OUT(bv), .BREADY_IN(b_r),
        .BRESP_OUT(br), .ARVALID_IN(ar_v), .ARREADY_OUT(arr), .ARADDR_IN(ar_a),
        .RVALID_OUT(rv), .RREADY_IN(r_r), .RDATA_OUT(rd), .RRESP_OUT(rr),
        .FETCH_REQ_IN(req), .FETCH_RSP_OUT(rsp), .LOAD_WE_IN(ld_we),
        .LOAD_ADDR_IN(ld_a), .LOAD_DATA_IN(ld_d), .VECTOR_BASE_OUT(base));
    cpu_fetch_model cpu (.clk_in(clk), .rst_n_in(nrst), .go_in(go),
        .addr_in(f_addr), .rsp_in(rsp), .req_out(req), .done_out(done),
        .data_out(f_data), .hit_out(f_hit), .lat_out(f_lat));
    // ************
    // helpers
    // ************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // lanes 1 and 2 move the base; lane 0 bits stay zero
    function automatic logic [23:0] nxt(logic [23:0] b, logic [31:0] x,
                                        logic [3:0] s);
        if (s[1]) b[15:8] = x[15:8];
        if (s[2]) b[23:16] = x[23:16];
        return b;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic summarize();
        if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    // write: offer address and data together, hold bready until answered
    task automatic axw(input logic [15:0] a, input logic [31:0] x,
                       input logic [3:0] s);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        aw_v <= 1'b1; aw_a <= a; w_v <= 1'b1; w_d <= x; w_s <= s; b_r <= 1'b1;
        forever begin
            @(posedge clk);
            if (pa && awr) begin pa = 1'b0; aw_v <= 1'b0; end
            if (pw && wr) begin pw = 1'b0; w_v <= 1'b0; end
            if (bv) begin r = br; b_r <= 1'b0; break; end
        end
    endtask
    task automatic axr(input logic [15:0] a);
        logic pa;
        pa = 1'b1;
        @(posedge clk);
        ar_v <= 1'b1; ar_a <= a; r_r <= 1'b1;
        forever begin
            @(posedge clk);
            if (pa && arr) begin pa = 1'b0; ar_v <= 1'b0; end
            if (rv) begin d = rd; r = rr; r_r <= 1'b0; break; end
        end
    endtask
    task automatic load(input logic [15:0] i, input logic [15:0] x);
        @(posedge clk);
        ld_we <= 1'b1; ld_a <= i; ld_d <= x;
        @(posedge clk);
        ld_we <= 1'b0;
    endtask
    // one fetch; model counts the taking edge, n waits and the answer edge
    task automatic fetch(input logic [23:0] a, input logic [15:0] ed,
                         input logic eh, input logic [2:0] n);
        @(posedge clk);
        go <= 1'b1; f_addr <= a;
        @(posedge clk);
        go <= 1'b0;
        for (int t = 0; t < 40 && !done; t++) @(posedge clk);
        chk(32'(f_lat), 32'(n) + 32'h2);
        chk(32'(f_hit), 32'(eh));
        chk(32'(f_data), 32'(ed));
    endtask
    // ************
    // stimulus
    // ************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end
    initial begin
        {nrst, aw_v, w_v, b_r, ar_v, r_r, ld_we, go} = '0;
        {aw_a, ar_a, ld_a, ld_d, w_d, w_s, f_addr} = '0;
        n_fail = 0;
        samples_checked = 0;
        seed = 32'h0000002F;
        do_reset();
        axr(rom_ctl_pkg::ADDR_WAIT); chk(d, 32'h00000007);
        axr(rom_ctl_pkg::ADDR_BASE_LOW); chk(d, 32'h00020000);
        eb = 24'h020000;
        // locked: base write answered but ignored
        axw(rom_ctl_pkg::ADDR_BASE_LOW, rnd(), 4'hF); chk(32'(r), 32'h0);
        chk(32'(base), 32'(eb));
        axw(rom_ctl_pkg::ADDR_UNLOCK, 32'h00000096, 4'hF);
        axr(rom_ctl_pkg::ADDR_UNLOCK); chk(d, 32'h00000096);
        chk(32'(r), 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            axw(rom_ctl_pkg::ADDR_BASE_LOW, v, (i == 3) ? 4'h4 : 4'hF);
            eb = nxt(eb, v, (i == 3) ? 4'h4 : 4'hF);
            axr(rom_ctl_pkg::ADDR_BASE_LOW); chk(d, {8'h00, eb});
            chk(32'(base), 32'(eb));
        end
        // relock as software should, stray write then bounces off
        axw(rom_ctl_pkg::ADDR_UNLOCK, 32'h0000005A, 4'hF);
        axw(rom_ctl_pkg::ADDR_BASE_LOW, ~{8'h00, eb}, 4'hF);
        chk(32'(base), 32'(eb));
        axw(16'h5808, rnd(), 4'hF); chk(32'(r), 32'h2);
        axr(16'h580C); chk(32'(r), 32'h2);
        // every wait setting, random rom word each time
        for (int n = 0; n < 8; n++) begin
            v = rnd();
            axw(rom_ctl_pkg::ADDR_WAIT, {v[31:3], 3'(n)}, 4'hF);
            axr(rom_ctl_pkg::ADDR_WAIT); chk(d, 32'(n));
            ix = v[31:16];
            load(ix, v[15:0]);
            fetch({7'h01, ix, 1'b0}, v[15:0], 1'b1, 3'(n));
        end
        // region edges at zero wait
        axw(rom_ctl_pkg::ADDR_WAIT, 32'h00000000, 4'hF);
        load(16'h0000, 16'hA5C3);
        load(16'hFFFF, 16'h3C5A);
        fetch(24'h01FFFE, 16'h0000, 1'b0, 3'h0);
        fetch(24'h020000, 16'hA5C3, 1'b1, 3'h0);
        fetch(24'h03FFFE, 16'h3C5A, 1'b1, 3'h0);
        fetch(24'h040000, 16'h0000, 1'b0, 3'h0);
        chk(32'(base), 32'(eb));
        do_reset();
        chk(32'(base), 32'h00020000);
        axr(rom_ctl_pkg::ADDR_WAIT); chk(d, 32'h00000007);
        summarize();
    end
endmodule
`default_nettype wire
